/* verilog/umsc_pkg.sv */
// Purpose: Constants of the serial mode, status and control block
// Assumes: Registers sit on 32-bit classic Wishbone, data in the low 16 bits
// Notes:   Offsets are byte addresses within a 16-byte window
//
// What this block does
// - Receive polarity bit set means a low serial input is idle.
// - Bit period is 4 samples in high-speed mode, 16 otherwise.
// - Frame field: 11 9-bit, 10 8-bit odd, 01 8-bit even, 00 8-bit none.
// - Stop-count select 1 sends two stop bits, 0 sends one.
// - Transmit event on load emptying buffer, on last shift-out, or every load.
// - Transmit inversion sets idle level, reversed when infrared codec is on.
// - Break request sends start, twelve zeros, stop, then clears itself.
// - Transmit enable drives line; clearing aborts, flushes buffer, releases line.
// - Read-only flag shows transmit buffer cannot take another character.
// - Read-only flag shows shift register and transmit buffer both empty.
// - Receive event on buffer reaching four, three, or any characters.
// - In 9-bit mode with detect on, only ninth-bit-set characters are kept.
// - Read-only flag is high while no character is being received.
// - Parity error flag belongs to the character at the buffer head.
// - Framing error flag belongs to the character at the buffer head.
// - Overrun set by hardware, cleared by software; clearing empties receiver.
// - Read-only flag shows at least one receive character is waiting.
// - Module enable off disables the transceiver and releases its pins.
// - Transmit and receive buffers are four-deep first-in first-out queues.
package umsc_pkg;
  localparam logic [3:0]  ADR_MODE    = 4'h0;
  localparam logic [3:0]  ADR_STA     = 4'h4;
  localparam logic [3:0]  ADR_TXD     = 4'h8;
  localparam logic [3:0]  ADR_RXD     = 4'hC;
  localparam logic [15:0] MODE_MASK   = 16'h901F;
  localparam logic [15:0] STA_WMASK   = 16'hECE0;
  localparam int          M_EN        = 15;
  localparam int          M_INFRARED_CODEC_ENABLE      = 12;
  localparam int          M_RXINV     = 4;
  localparam int          M_HIGH_SPEED_BAUD_SELECT      = 3;
  localparam int          M_STOP_COUNT_SELECT     = 0;
  localparam int          S_TXIS1     = 15;
  localparam int          S_TXINV     = 14;
  localparam int          S_TXIS0     = 13;
  localparam int          S_BRK       = 11;
  localparam int          S_TXEN      = 10;
  localparam int          S_TXBF      = 9;
  localparam int          S_TRANSMITTER_EMPTY      = 8;
  localparam int          S_ADDRESS_DETECT_ENABLE     = 5;
  localparam int          S_RECEIVER_IDLE     = 4;
  localparam int          S_PARITY_ERROR_FLAG      = 3;
  localparam int          S_FRAMING_ERROR_FLAG      = 2;
  localparam int          S_OVERRUN_FLAG      = 1;
  localparam int          S_RXDA      = 0;
  localparam logic [1:0]  PD_9N       = 2'h3;
  localparam logic [1:0]  PD_8O       = 2'h2;
  localparam logic [1:0]  PD_8N       = 2'h0;
  localparam logic [1:0]  TXI_EMPTY   = 2'h2;
  localparam logic [1:0]  TXI_DONE    = 2'h1;
  localparam logic [1:0]  TXI_EACH    = 2'h0;
  localparam logic [1:0]  RXI_FULL    = 2'h3;
  localparam logic [1:0]  RXI_3Q      = 2'h2;
  localparam logic [2:0]  RX_LVL_FULL = 3'h4;
  localparam logic [2:0]  RX_LVL_3Q   = 3'h3;
  localparam logic [3:0]  SPB_HI_M1   = 4'h3;
  localparam logic [3:0]  SPB_STD_M1  = 4'hF;
  localparam logic [3:0]  BITS_BRK    = 4'hC;
  localparam logic [3:0]  BITS_9      = 4'h9;
  localparam logic [3:0]  BITS_8      = 4'h8;
  localparam logic [3:0]  IR_PULSE    = 4'h3;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h3,
    ST_PAR   = 3'h2,
    ST_STOP  = 3'h6
  } umsc_state_e;
endpackage : umsc_pkg

/* verilog/umsc_top.sv */
// Purpose: Serial transceiver with mode, status and control registers
// Assumes: One clock; serial_in is asynchronous and synchronised here
// Notes:   Event outputs are one-cycle pulses, no interrupt logic here
`timescale 1ns/1ns
`default_nettype none
module umsc_top #(
  parameter logic [15:0] BAUD_DIV = 16'h000D,
  parameter int          AW       = 2
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_oe,
  output logic             tx_event,
  output logic             rx_event
);
  localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
  localparam logic [AW:0] ONE   = {{AW{1'b0}}, 1'b1};

  logic [15:0] mode;
  logic [15:0] sta_ctl;
  logic        overrun;
  logic [15:0] baud_cnt;
  logic        tick;
  logic        sync1;
  logic        sync2;

  ////////////////////////////////////////////////////////////////////
  // Wishbone slave
  logic        req;
  logic        wr;
  logic [15:0] wdat;
  logic [15:0] cur;
  logic [15:0] rdat;
  logic        wr_mode;
  logic        wr_sta;
  logic        tx_push;
  logic        rx_pop;
  logic        overrun_flag_clr;

  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr       = req & wb_we_i;
  assign wr_mode  = wr & (wb_adr_i == umsc_pkg::ADR_MODE);
  assign wr_sta   = wr & (wb_adr_i == umsc_pkg::ADR_STA);
  assign cur      = (wb_adr_i == umsc_pkg::ADR_MODE) ? mode : sta_ctl;
  assign wdat     = {wb_sel_i[1] ? wb_dat_i[15:8] : cur[15:8],
                     wb_sel_i[0] ? wb_dat_i[7:0] : cur[7:0]};
  // Overrun can only be cleared by writing zero over a set flag
  assign overrun_flag_clr = wr_sta & wb_sel_i[0] & overrun & ~wb_dat_i[umsc_pkg::S_OVERRUN_FLAG];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= {16'h0000, rdat};
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode <= 16'h0000;
    end else if (wr_mode) begin
      mode <= wdat & umsc_pkg::MODE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Baud sampling tick and input synchroniser
  logic       enabled;
  logic       txen;
  logic [3:0] spb_m1;
  logic       nine;
  logic       par_on;

  assign enabled = mode[umsc_pkg::M_EN];
  assign txen    = enabled & sta_ctl[umsc_pkg::S_TXEN];
  assign spb_m1  = mode[umsc_pkg::M_HIGH_SPEED_BAUD_SELECT] ? umsc_pkg::SPB_HI_M1
                                          : umsc_pkg::SPB_STD_M1;
  assign nine    = (mode[2:1] == umsc_pkg::PD_9N);
  assign par_on  = ~nine & (mode[2:1] != umsc_pkg::PD_8N);
  assign tick    = (baud_cnt == BAUD_DIV - 16'h0001);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      baud_cnt <= 16'h0000;
    end else if (!enabled || tick) begin
      baud_cnt <= 16'h0000;
    end else begin
      baud_cnt <= baud_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else begin
      sync1 <= serial_in;
      sync2 <= sync1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transmit queue and shifter
  logic [8:0]            tx_mem [2**AW];
  logic [AW-1:0]         tx_rd;
  logic [AW-1:0]         tx_wr;
  logic [AW:0]           tx_cnt;
  logic                  tx_pop;
  logic                  tx_start;
  logic                  brk;
  umsc_pkg::umsc_state_e tx_st;
  logic [8:0]            tx_sh;
  logic [3:0]            tx_nb;
  logic [3:0]            tx_bc;
  logic [3:0]            tx_ph;
  logic                  tx_par;
  logic                  tx_brk;
  logic                  tx_stop2;
  logic                  tx_bit;
  logic                  tx_bend;
  logic                  tx_done;

  assign tx_push  = wr & (wb_adr_i == umsc_pkg::ADR_TXD) & txen & (tx_cnt != DEPTH);
  assign tx_start = txen & (tx_st == umsc_pkg::ST_IDLE) & (brk | (tx_cnt != '0));
  assign tx_pop   = tx_start & ~brk;
  assign tx_bend  = tick & (tx_ph == spb_m1);
  assign tx_done  = tx_bend & (tx_st == umsc_pkg::ST_STOP) &
                    ~(mode[umsc_pkg::M_STOP_COUNT_SELECT] & ~tx_stop2);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_rd  <= '0;
      tx_wr  <= '0;
      tx_cnt <= '0;
    end else if (!txen) begin
      tx_rd  <= '0;
      tx_wr  <= '0;
      tx_cnt <= '0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wr] <= wb_dat_i[8:0];
        tx_wr         <= tx_wr + 1'b1;
      end
      if (tx_pop) begin
        tx_rd <= tx_rd + 1'b1;
      end
      tx_cnt <= tx_cnt + (tx_push ? ONE : '0) - (tx_pop ? ONE : '0);
    end
  end

  always_comb begin
    unique case (tx_st)
      umsc_pkg::ST_START: tx_bit = 1'b0;
      umsc_pkg::ST_DATA:  tx_bit = tx_sh[0];
      umsc_pkg::ST_PAR:   tx_bit = tx_par;
      umsc_pkg::ST_STOP:  tx_bit = 1'b1;
      default:            tx_bit = 1'b1;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_st    <= umsc_pkg::ST_IDLE;
      tx_sh    <= 9'h000;
      tx_nb    <= 4'h0;
      tx_bc    <= 4'h0;
      tx_ph    <= 4'h0;
      tx_par   <= 1'b0;
      tx_brk   <= 1'b0;
      tx_stop2 <= 1'b0;
    end else if (!txen) begin
      tx_st  <= umsc_pkg::ST_IDLE;
      tx_brk <= 1'b0;
    end else if (tx_start) begin
      tx_st    <= umsc_pkg::ST_START;
      tx_ph    <= 4'h0;
      tx_bc    <= 4'h0;
      tx_stop2 <= 1'b0;
      tx_brk   <= brk;
      tx_sh    <= brk ? 9'h000 : tx_mem[tx_rd];
      tx_nb    <= brk ? umsc_pkg::BITS_BRK
                      : (nine ? umsc_pkg::BITS_9 : umsc_pkg::BITS_8);
      tx_par   <= (^tx_mem[tx_rd][7:0]) ^ (mode[2:1] == umsc_pkg::PD_8O);
    end else if (tick) begin
      tx_ph <= tx_bend ? 4'h0 : tx_ph + 4'h1;
      if (tx_bend) begin
        unique case (tx_st)
          umsc_pkg::ST_START: tx_st <= umsc_pkg::ST_DATA;
          umsc_pkg::ST_DATA: begin
            tx_sh <= {1'b0, tx_sh[8:1]};
            tx_bc <= tx_bc + 4'h1;
            if (tx_bc == tx_nb - 4'h1) begin
              tx_st <= (par_on & ~tx_brk) ? umsc_pkg::ST_PAR : umsc_pkg::ST_STOP;
            end
          end
          umsc_pkg::ST_PAR:  tx_st <= umsc_pkg::ST_STOP;
          umsc_pkg::ST_STOP: begin
            tx_stop2 <= 1'b1;
            if (tx_done) begin
              tx_st <= umsc_pkg::ST_IDLE;
            end
          end
          default: tx_st <= umsc_pkg::ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status and control register
  logic brk_clr;

  assign brk     = sta_ctl[umsc_pkg::S_BRK];
  assign brk_clr = tx_done & tx_brk;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sta_ctl <= 16'h0000;
    end else begin
      if (wr_sta) begin
        sta_ctl <= wdat & umsc_pkg::STA_WMASK;
      end
      // A software set in the same cycle wins over the self-clear
      if (brk_clr && !(wr_sta && wdat[umsc_pkg::S_BRK])) begin
        sta_ctl[umsc_pkg::S_BRK] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receiver
  logic [10:0]           rx_mem [2**AW];
  logic [AW-1:0]         rx_rd;
  logic [AW-1:0]         rx_wr;
  logic [AW:0]           rx_cnt;
  logic [AW:0]           rx_lvl;
  umsc_pkg::umsc_state_e rx_st;
  logic [8:0]            rsr;
  logic [3:0]            rx_bc;
  logic [3:0]            rx_ph;
  logic                  rx_parity_error_flag;
  logic                  rxd;
  logic                  rx_samp;
  logic                  rx_end;
  logic                  rx_keep;
  logic                  rx_push;
  logic [8:0]            rx_char;

  assign rxd     = sync2 ^ mode[umsc_pkg::M_RXINV];
  assign rx_samp = tick & (rx_ph == ((rx_st == umsc_pkg::ST_START) ?
                                     {1'b0, spb_m1[3:1]} + 4'h1 : spb_m1));
  assign rx_end  = rx_samp & (rx_st == umsc_pkg::ST_STOP);
  assign rx_char = nine ? rsr : {1'b0, rsr[8:1]};
  // Overrun holds off every transfer so the queued characters survive
  assign rx_keep = ~overrun & ~(sta_ctl[umsc_pkg::S_ADDRESS_DETECT_ENABLE] & nine & ~rsr[8]);
  assign rx_push = rx_end & rx_keep & (rx_cnt != DEPTH);
  assign rx_pop  = req & ~wb_we_i & (wb_adr_i == umsc_pkg::ADR_RXD) & (rx_cnt != '0);
  assign rx_lvl  = rx_cnt + ONE - (rx_pop ? ONE : '0);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_st   <= umsc_pkg::ST_IDLE;
      rsr     <= 9'h000;
      rx_bc   <= 4'h0;
      rx_ph   <= 4'h0;
      rx_parity_error_flag <= 1'b0;
    end else if (!enabled || overrun_flag_clr) begin
      rx_st <= umsc_pkg::ST_IDLE;
      rsr   <= 9'h000;
    end else if (rx_st == umsc_pkg::ST_IDLE) begin
      rx_ph <= 4'h0;
      rx_bc <= 4'h0;
      if (!rxd) begin
        rx_st <= umsc_pkg::ST_START;
      end
    end else if (tick) begin
      rx_ph <= rx_samp ? 4'h0 : rx_ph + 4'h1;
      if (rx_samp) begin
        unique case (rx_st)
          umsc_pkg::ST_START: rx_st <= rxd ? umsc_pkg::ST_IDLE : umsc_pkg::ST_DATA;
          umsc_pkg::ST_DATA: begin
            rsr   <= {rxd, rsr[8:1]};
            rx_bc <= rx_bc + 4'h1;
            rx_parity_error_flag <= 1'b0;
            if (rx_bc == (nine ? umsc_pkg::BITS_9 : umsc_pkg::BITS_8) - 4'h1) begin
              rx_st <= par_on ? umsc_pkg::ST_PAR : umsc_pkg::ST_STOP;
            end
          end
          umsc_pkg::ST_PAR: begin
            rx_parity_error_flag <= rxd ^ (^rsr[8:1]) ^ (mode[2:1] == umsc_pkg::PD_8O);
            rx_st   <= umsc_pkg::ST_STOP;
          end
          umsc_pkg::ST_STOP: rx_st <= umsc_pkg::ST_IDLE;
          default:           rx_st <= umsc_pkg::ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_rd  <= '0;
      rx_wr  <= '0;
      rx_cnt <= '0;
    end else if (overrun_flag_clr || !enabled) begin
      rx_rd  <= '0;
      rx_wr  <= '0;
      rx_cnt <= '0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wr] <= {~rxd, rx_parity_error_flag, rx_char};
        rx_wr         <= rx_wr + 1'b1;
      end
      if (rx_pop) begin
        rx_rd <= rx_rd + 1'b1;
      end
      rx_cnt <= rx_cnt + (rx_push ? ONE : '0) - (rx_pop ? ONE : '0);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      overrun <= 1'b0;
    end else if (rx_end && rx_keep && rx_cnt == DEPTH) begin
      overrun <= 1'b1;
    end else if (overrun_flag_clr) begin
      overrun <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux, events and line driver
  logic [10:0] rx_head;

  assign rx_head = (rx_cnt != '0) ? rx_mem[rx_rd] : 11'h000;

  always_comb begin
    rdat = 16'h0000;
    unique case (wb_adr_i)
      umsc_pkg::ADR_MODE: rdat = mode;
      umsc_pkg::ADR_STA: begin
        rdat = sta_ctl;
        rdat[umsc_pkg::S_TXBF]  = (tx_cnt == DEPTH);
        rdat[umsc_pkg::S_TRANSMITTER_EMPTY]  = (tx_st == umsc_pkg::ST_IDLE) & (tx_cnt == '0);
        rdat[umsc_pkg::S_RECEIVER_IDLE] = (rx_st == umsc_pkg::ST_IDLE);
        rdat[umsc_pkg::S_PARITY_ERROR_FLAG]  = rx_head[9];
        rdat[umsc_pkg::S_FRAMING_ERROR_FLAG]  = rx_head[10];
        rdat[umsc_pkg::S_OVERRUN_FLAG]  = overrun;
        rdat[umsc_pkg::S_RXDA]  = (rx_cnt != '0);
      end
      umsc_pkg::ADR_RXD:  rdat = {7'h00, rx_head[8:0]};
      default:            rdat = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_event <= 1'b0;
    end else begin
      unique case ({sta_ctl[umsc_pkg::S_TXIS1], sta_ctl[umsc_pkg::S_TXIS0]})
        umsc_pkg::TXI_EACH:  tx_event <= tx_pop;
        umsc_pkg::TXI_EMPTY: tx_event <= tx_pop & (tx_cnt == ONE) & ~tx_push;
        umsc_pkg::TXI_DONE:  tx_event <= tx_done & (tx_cnt == '0);
        default:             tx_event <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_event <= 1'b0;
    end else begin
      unique case (sta_ctl[7:6])
        umsc_pkg::RXI_FULL: rx_event <= rx_push & (rx_lvl == umsc_pkg::RX_LVL_FULL);
        umsc_pkg::RXI_3Q:   rx_event <= rx_push & (rx_lvl == umsc_pkg::RX_LVL_3Q);
        default:            rx_event <= rx_push;
      endcase
    end
  end

  // Infrared pulse covers the first three sample periods of each zero bit (3/16 of a bit, 3/4 in high-speed mode)
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      serial_out    <= 1'b1;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= txen;
      if (mode[umsc_pkg::M_INFRARED_CODEC_ENABLE]) begin
        serial_out <= (~tx_bit & (tx_ph < umsc_pkg::IR_PULSE)) ^ sta_ctl[umsc_pkg::S_TXINV];
      end else begin
        serial_out <= tx_bit ^ sta_ctl[umsc_pkg::S_TXINV];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  a_ack_next: assert property (@(posedge clock) disable iff (!reset_n)
    req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");
  a_tx_idle_level: assert property (@(posedge clock) disable iff (!reset_n)
    (txen && tx_st == umsc_pkg::ST_IDLE && !tx_start && !mode[umsc_pkg::M_INFRARED_CODEC_ENABLE]) |=>
    serial_out == !$past(sta_ctl[umsc_pkg::S_TXINV])) else $error("bad tx idle");
  a_txen_flush: assert property (@(posedge clock) disable iff (!reset_n)
    !txen |=> (tx_cnt == '0 && tx_st == umsc_pkg::ST_IDLE && !serial_out_oe))
    else $error("tx not flushed");
  a_tx_no_overfill: assert property (@(posedge clock) disable iff (!reset_n)
    tx_cnt <= DEPTH) else $error("tx overfill");
  a_break_clear: assert property (@(posedge clock) disable iff (!reset_n)
    (brk_clr && !wr_sta) |=> !brk) else $error("break not cleared");
  a_break_zeros: assert property (@(posedge clock) disable iff (!reset_n)
    (tx_start && brk) |=> tx_nb == umsc_pkg::BITS_BRK) else $error("break length");
  a_phase_bound: assert property (@(posedge clock) disable iff (!reset_n)
    tx_ph <= spb_m1 || $changed(mode[umsc_pkg::M_HIGH_SPEED_BAUD_SELECT]) || $past(tx_ph > spb_m1))
    else $error("phase beyond bit");
  a_overrun_hold: assert property (@(posedge clock) disable iff (!reset_n)
    (overrun && !overrun_flag_clr) |=> rx_cnt <= $past(rx_cnt)) else $error("push in overrun");
  a_overrun_flush: assert property (@(posedge clock) disable iff (!reset_n)
    overrun_flag_clr |=> (rx_cnt == '0 && !overrun && rx_st == umsc_pkg::ST_IDLE))
    else $error("overrun clear no flush");
  a_rx_addr: assert property (@(posedge clock) disable iff (!reset_n)
    (rx_end && nine && sta_ctl[umsc_pkg::S_ADDRESS_DETECT_ENABLE] && !rsr[8]) |-> !rx_push)
    else $error("data kept in address mode");
  a_rx_event_lvl: assert property (@(posedge clock) disable iff (!reset_n)
    (rx_push && sta_ctl[7:6] == umsc_pkg::RXI_FULL && rx_lvl != umsc_pkg::RX_LVL_FULL)
    |=> !rx_event) else $error("early rx event");
endmodule : umsc_top
`default_nettype wire

/* test/umsc_remote.sv */
// Purpose: Remote serial device facing the transceiver line
// Assumes: Frames of eight data bits seen, bit time given in clocks
// Notes:   Line reads as pulled high whenever the block releases it
`timescale 1ns/1ns
`default_nettype none
module umsc_remote #(
  parameter int BIT_CLK = 32
) (
  input  wire logic       clock,
  input  wire logic       line_in,
  input  wire logic       line_oe,
  output logic            line_out,
  output logic            got_valid,
  output logic      [7:0] got_data
);
  logic wire_lvl;
  assign wire_lvl = line_oe ? line_in : 1'b1;
  initial begin
    line_out  = 1'b1;
    got_valid = 1'b0;
    got_data  = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic bit_out(input logic b);
    @(posedge clock);
    line_out <= b;
    repeat (BIT_CLK - 1) @(posedge clock);
  endtask : bit_out
  task automatic send(input logic [8:0] d, input int nb, input logic hp, input logic pb);
    bit_out(1'b0);
    for (int i = 0; i < nb; i++) bit_out(d[i]);
    if (hp) bit_out(pb);
    bit_out(1'b1);
  endtask : send
  ////////////////////////////////////////////////////////////////////
  // Sample mid-bit, LSB first
  always begin
    @(negedge wire_lvl);
    repeat (BIT_CLK / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLK) @(posedge clock);
      got_data[i] = wire_lvl;
    end
    repeat (BIT_CLK) @(posedge clock);
    got_valid <= 1'b1;
    @(posedge clock);
    got_valid <= 1'b0;
  end
endmodule : umsc_remote
`default_nettype wire

/* test/uart_mode_status_control_test.sv */
// Purpose: Self-checking bench of the serial mode and status block
// Assumes: BAUD_DIV of 2 with 16x sampling, so one bit is 32 clocks
// Notes:   Expected reads and sent bytes are queued for a monitor
`timescale 1ns/1ns
`default_nettype none
module uart_mode_status_control_test;
  localparam int BIT_CLK = 32;
  logic        clock, reset_n, cyc, stb, we, ack, sout, soe, sin, gv, txe, rxe;
  int          tx_ev_n = 0;
  int          rx_ev_n = 0;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, dat_o, m;
  logic [7:0]  gd, b;
  logic [31:0] exp_rd[$], exp_mask[$];
  logic [7:0]  exp_tx[$];
  int          error_cnt, check_count, n;
  umsc_top #(.BAUD_DIV(16'h0002)) dut_u (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .serial_in(sin), .serial_out(sout),
    .serial_out_oe(soe), .tx_event(txe), .rx_event(rxe));
  umsc_remote #(.BIT_CLK(BIT_CLK)) peer (.clock(clock), .line_in(sout), .line_oe(soe),
    .line_out(sin), .got_valid(gv), .got_data(gd));
  ////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // Hold request until ack is seen at an edge, then drop for a cycle
  task automatic xfer(input logic w, input logic [3:0] a, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clock);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) error_cnt++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] mk);
    exp_rd.push_back({16'h0000, e});
    exp_mask.push_back({16'h0000, mk});
    xfer(1'b0, a, 16'h0000);
  endtask : rd
  // Wait for queued bytes to be seen, then let the last frame end
  task automatic tx_drain();
    n = 0;
    while (exp_tx.size() > 0 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 4000) error_cnt++;
    repeat (6 * BIT_CLK) @(posedge clock);
  endtask : tx_drain
  task automatic rx_char(input logic [7:0] d, input logic hp, input logic pb);
    peer.send({1'b0, d}, 8, hp, pb);
  endtask : rx_char
  ////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (ack === 1'b1 && we === 1'b0 && exp_rd.size() > 0) begin
      m = exp_mask.pop_front();
      check("register read", exp_rd.pop_front() & m, dat_o & m);
    end
    if (gv === 1'b1) check("sent byte", {24'h0, exp_tx.pop_front()}, {24'h0, gd});
    if (txe === 1'b1) tx_ev_n++;
    if (rxe === 1'b1) rx_ev_n++;
  end
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #(40 * 15000);
    error_cnt++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, cyc, stb, we, adr, wdat, error_cnt, check_count} = '0;
    sel = 4'h3;
    void'($urandom(32'h871a));
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rd(umsc_pkg::ADR_MODE, 16'h0000, 16'hFFFF);
    rd(umsc_pkg::ADR_STA, 16'h0110, 16'hFFFF);
    rd(4'h2, 16'h0000, 16'hFFFF);
    xfer(1'b1, umsc_pkg::ADR_MODE, 16'h8000);
    xfer(1'b1, umsc_pkg::ADR_STA, 16'h0400);
    for (int i = 0; i < 5; i++) begin
      b = 8'($urandom);
      exp_tx.push_back(b);
      xfer(1'b1, umsc_pkg::ADR_TXD, {8'h00, b});
    end
    check("line enable", 32'h1, {31'h0, soe});
    rd(umsc_pkg::ADR_STA, 16'h0200, 16'h0300);
    tx_drain();
    rd(umsc_pkg::ADR_STA, 16'h0100, 16'h0300);
    exp_tx.push_back(8'h00);
    xfer(1'b1, umsc_pkg::ADR_STA, 16'h0C00);
    tx_drain();
    rd(umsc_pkg::ADR_STA, 16'h0500, 16'h0F00);
    b = 8'($urandom);
    rx_char(b, 1'b0, 1'b0);
    rd(umsc_pkg::ADR_STA, 16'h0011, 16'h001F);
    rd(umsc_pkg::ADR_RXD, {8'h00, b}, 16'h01FF);
    xfer(1'b1, umsc_pkg::ADR_STA, 16'h0480);
    for (int i = 0; i < 5; i++) rx_char(8'($urandom), 1'b0, 1'b0);
    rd(umsc_pkg::ADR_STA, 16'h0003, 16'h0003);
    xfer(1'b1, umsc_pkg::ADR_STA, 16'h0400);
    rd(umsc_pkg::ADR_STA, 16'h0000, 16'h0003);
    xfer(1'b1, umsc_pkg::ADR_MODE, 16'h8002);
    b = 8'($urandom);
    rx_char(b, 1'b1, ~^b);
    rd(umsc_pkg::ADR_STA, 16'h0009, 16'h000D);
    rd(umsc_pkg::ADR_RXD, {8'h00, b}, 16'h01FF);
    xfer(1'b1, umsc_pkg::ADR_MODE, 16'h8004);
    rx_char(b, 1'b1, ~^b);
    rd(umsc_pkg::ADR_STA, 16'h0001, 16'h000D);
    rd(umsc_pkg::ADR_RXD, {8'h00, b}, 16'h01FF);
    rd(umsc_pkg::ADR_STA, 16'h0000, 16'h0001);
    check("tx events", 32'h5, tx_ev_n);
    check("rx events", 32'h4, rx_ev_n);
    wrap_up();
  end
endmodule : uart_mode_status_control_test
`default_nettype wire
